// >>> hdl/eot_defs.svh
`ifndef EOT_DEFS_SVH
`define EOT_DEFS_SVH

// register subaddresses
`define EOT_ADDR_W 8
`define EOT_OFS_MODE3 8'h12
`define EOT_OFS_TTX_TIMING 8'h24

// mode register three fields
`define EOT_M3_REVISION 0
`define EOT_M3_VBI_PASS 1
`define EOT_M3_TTX_EN 4
`define EOT_M3_DEF_COLOUR 6
`define EOT_M3_OUT_SWITCH 7
`define EOT_M3_WRITABLE_MASK 8'hD2

// teletext request timing fields
`define EOT_TT_RISE_HI 7
`define EOT_TT_RISE_LO 4
`define EOT_TT_FALL_HI 3
`define EOT_TT_FALL_LO 0

// reset values
`define EOT_RST_MODE3 8'h00
`define EOT_RST_TTX_TIMING 8'h00
`define EOT_REVISION_DEFAULT 1'b0

// video levels
`define EOT_BLACK_LEVEL 8'h10
`define EOT_ZERO_WORD 8'h00

// teletext request window: 360 bits, 37 bits per 144 clocks
`define EOT_TTX_BITS 360
`define EOT_TTX_CLK_PER_GROUP 144
`define EOT_TTX_BITS_PER_GROUP 37
`define EOT_TTX_WINDOW_CYCLES ((`EOT_TTX_BITS * `EOT_TTX_CLK_PER_GROUP) / `EOT_TTX_BITS_PER_GROUP)
`define EOT_TTX_CNT_W 11

`endif

// >>> hdl/eot_pkg.sv
package eot_pkg;

    typedef enum logic [2:0] {
        EOT_SIG_CVBS = 3'h0,
        EOT_SIG_Y = 3'h1,
        EOT_SIG_C = 3'h2,
        EOT_SIG_R = 3'h3,
        EOT_SIG_G = 3'h4,
        EOT_SIG_B = 3'h5,
        EOT_SIG_U = 3'h6,
        EOT_SIG_V = 3'h7
    } eot_sig_t;

    typedef struct packed {
        eot_sig_t dac_a;
        eot_sig_t dac_b;
        eot_sig_t dac_c;
        eot_sig_t dac_d;
    } eot_route_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } eot_reg_req_t;

    typedef struct packed {
        logic rgb_select;
        logic yuv_select;
        logic blank_input_control;
        logic slave_mode0;
        logic [3:0] dac_power_down;
    } eot_ext_cfg_t;

    typedef enum logic [2:0] {
        EOT_TTX_IDLE = 3'b001,
        EOT_TTX_WAIT = 3'b010,
        EOT_TTX_ACTIVE = 3'b100
    } eot_ttx_state_t;

    typedef struct packed {
        eot_ttx_state_t state;
        logic [10:0] count;
        logic req;
    } eot_ttx_q_t;

    typedef struct packed {
        logic [7:0] mode3;
        logic [7:0] ttx_timing;
        logic [7:0] rdata;
        logic [7:0] vid_meta;
        logic [7:0] vid_sync;
        logic [7:0] vid_out;
        logic vid_blanked;
        logic ttx_meta;
        logic ttx_sync;
        logic ttx_bit;
        logic ttx_insert;
        eot_route_t route;
        logic [3:0] dac_enable;
        logic revision;
    } eot_top_q_t;

endpackage

// >>> hdl/eot_ttx_request.sv
`timescale 1ns/1ns
`include "eot_defs.svh"

module eot_ttx_request (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic line_start_i,
    input wire logic window_en_i,
    input wire logic [3:0] rise_delay_i,
    input wire logic [3:0] fall_delay_i,
    output logic request_o
);
    import eot_pkg::*;

    localparam logic [10:0] WINDOW = 11'(`EOT_TTX_WINDOW_CYCLES);

    eot_ttx_q_t q;
    eot_ttx_q_t d;

    // width depends only on the falling nibble, so moving the rise moves the fall too
    function automatic logic [10:0] width_of(input logic [3:0] fall);
        width_of = WINDOW - {7'h00, fall};
    endfunction

    always_comb begin
        d = q;
        unique case (q.state)
            EOT_TTX_IDLE: begin
                d.req = 1'b0;
                if (line_start_i && window_en_i) begin
                    if (rise_delay_i == 4'h0) begin
                        d.state = EOT_TTX_ACTIVE;
                        d.count = width_of(fall_delay_i) - 11'h001;
                        d.req = 1'b1;
                    end else begin
                        d.state = EOT_TTX_WAIT;
                        d.count = {7'h00, rise_delay_i} - 11'h001;
                    end
                end
            end
            EOT_TTX_WAIT: begin
                if (!window_en_i) begin
                    d.state = EOT_TTX_IDLE;
                end else if (q.count == 11'h000) begin
                    d.state = EOT_TTX_ACTIVE;
                    d.count = width_of(fall_delay_i) - 11'h001;
                    d.req = 1'b1;
                end else begin
                    d.count = q.count - 11'h001;
                end
            end
            EOT_TTX_ACTIVE: begin
                if (!window_en_i || q.count == 11'h000) begin
                    d.state = EOT_TTX_IDLE;
                    d.req = 1'b0;
                end else begin
                    d.count = q.count - 11'h001;
                end
            end
            default: begin
                d.state = EOT_TTX_IDLE;
                d.req = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            q <= '{state: EOT_TTX_IDLE, count: 11'h000, req: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign request_o = q.req;

endmodule // eot_ttx_request

// >>> hdl/eot_output_control.sv
`timescale 1ns/1ns
`include "eot_defs.svh"

// Operation
// - one read-only revision bit in mode register three; writes ignored
// - pass-through set forwards blanking-interval data; clear blanks it
// - pass-through is ignored in slave timing mode 0
// - blank-input control overrides pass-through when both are enabled
// - teletext inserted only while teletext enable is 1; host sets it
// - default-colour 0: all-zero or missing input shows its own colour
// - default-colour 1: all-zero input forces outputs to black
// - dacs routed from rgb-select, yuv-select and output-switch bits
// - output switch: dac a takes dac d signal, dac d carries composite
// - each dac powered down by its own bit, 1 means off
// - 8-bit teletext request timing register at address 24h
// - request rising edge delayed by upper nibble, 0 to 15 cycles
// - request falling edge shifted by lower nibble, 0 to 15 cycles
// - larger falling value shortens window below 360 bits
// - changing only rising nibble keeps the request width constant
module eot_output_control #(
    parameter logic REVISION_BIT = `EOT_REVISION_DEFAULT // arbitrary value
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input eot_pkg::eot_reg_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    input eot_pkg::eot_ext_cfg_t ext_cfg_i,
    input wire logic [7:0] video_data_i,
    input wire logic vbi_active_i,
    input wire logic line_start_i,
    input wire logic ttx_line_enable_i,
    input wire logic teletext_data_input_i,
    output logic [7:0] video_data_o,
    output logic video_blanked_o,
    output eot_pkg::eot_route_t dac_route_o,
    output logic [3:0] dac_enable_o,
    output logic teletext_request_strobe_o,
    output logic teletext_bit_o,
    output logic teletext_insert_o
);
    import eot_pkg::*;

    eot_top_q_t q;
    eot_top_q_t d;
    logic req_strobe;

    function automatic logic [7:0] mode3_view(input logic [7:0] stored, input logic rev);
        mode3_view = stored & `EOT_M3_WRITABLE_MASK;
        mode3_view[`EOT_M3_REVISION] = rev;
    endfunction

    function automatic eot_route_t route_of(input logic rgb, input logic yuv, input logic sw);
        eot_route_t r;
        r.dac_a = EOT_SIG_CVBS;
        r.dac_b = EOT_SIG_CVBS;
        r.dac_c = EOT_SIG_C;
        r.dac_d = EOT_SIG_Y;
        if (rgb) begin
            r.dac_b = yuv ? EOT_SIG_U : EOT_SIG_B;
            r.dac_c = yuv ? EOT_SIG_V : EOT_SIG_R;
            r.dac_d = yuv ? EOT_SIG_Y : EOT_SIG_G;
        end
        if (sw) begin
            r.dac_a = r.dac_d;
            r.dac_d = EOT_SIG_CVBS;
        end
        route_of = r;
    endfunction

    eot_ttx_request u_ttx_request (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .line_start_i(line_start_i),
        .window_en_i(q.mode3[`EOT_M3_TTX_EN] && ttx_line_enable_i),
        .rise_delay_i(q.ttx_timing[`EOT_TT_RISE_HI:`EOT_TT_RISE_LO]),
        .fall_delay_i(q.ttx_timing[`EOT_TT_FALL_HI:`EOT_TT_FALL_LO]),
        .request_o(req_strobe)
    );

    always_comb begin
        logic pass_ok;
        logic blank_now;
        pass_ok = 1'b0;
        blank_now = 1'b0;
        d = q;

        // register writes
        if (reg_req_i.wr) begin
            if (reg_req_i.addr == `EOT_OFS_MODE3) begin
                d.mode3 = reg_req_i.wdata & `EOT_M3_WRITABLE_MASK;
            end
            if (reg_req_i.addr == `EOT_OFS_TTX_TIMING) begin
                d.ttx_timing = reg_req_i.wdata;
            end
        end

        // register reads, answered next cycle
        if (reg_req_i.rd) begin
            if (reg_req_i.addr == `EOT_OFS_MODE3) begin
                d.rdata = mode3_view(q.mode3, q.revision);
            end else if (reg_req_i.addr == `EOT_OFS_TTX_TIMING) begin
                d.rdata = q.ttx_timing;
            end else begin
                d.rdata = 8'h00;
            end
        end

        // pixel path: pin data passes two flops first
        d.vid_meta = video_data_i;
        d.vid_sync = q.vid_meta;
        pass_ok = q.mode3[`EOT_M3_VBI_PASS] && !ext_cfg_i.slave_mode0
            && !ext_cfg_i.blank_input_control;
        blank_now = vbi_active_i && !pass_ok;
        if (blank_now) begin
            d.vid_out = `EOT_BLACK_LEVEL;
        end else if (q.vid_sync == `EOT_ZERO_WORD && q.mode3[`EOT_M3_DEF_COLOUR]) begin
            d.vid_out = `EOT_BLACK_LEVEL;
        end else begin
            d.vid_out = q.vid_sync;
        end
        d.vid_blanked = blank_now;

        // teletext pin synchronised, gated by request window and enable
        d.ttx_meta = teletext_data_input_i;
        d.ttx_sync = q.ttx_meta;
        d.ttx_insert = req_strobe && q.mode3[`EOT_M3_TTX_EN];
        d.ttx_bit = (req_strobe && q.mode3[`EOT_M3_TTX_EN]) ? q.ttx_sync : 1'b0;

        // dac routing and power
        d.route = route_of(ext_cfg_i.rgb_select, ext_cfg_i.yuv_select,
            q.mode3[`EOT_M3_OUT_SWITCH]);
        d.dac_enable = ~ext_cfg_i.dac_power_down;
        d.revision = REVISION_BIT;
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            q.mode3 <= `EOT_RST_MODE3;
            q.ttx_timing <= `EOT_RST_TTX_TIMING;
            q.rdata <= 8'h00;
            q.vid_meta <= 8'h00;
            q.vid_sync <= 8'h00;
            q.vid_out <= 8'h00;
            q.vid_blanked <= 1'b0;
            q.ttx_meta <= 1'b0;
            q.ttx_sync <= 1'b0;
            q.ttx_bit <= 1'b0;
            q.ttx_insert <= 1'b0;
            q.route <= '{dac_a: EOT_SIG_CVBS, dac_b: EOT_SIG_CVBS, dac_c: EOT_SIG_C,
                         dac_d: EOT_SIG_Y};
            q.dac_enable <= 4'h0;
            q.revision <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata_o = q.rdata;
    assign video_data_o = q.vid_out;
    assign video_blanked_o = q.vid_blanked;
    assign dac_route_o = q.route;
    assign dac_enable_o = q.dac_enable;
    assign teletext_request_strobe_o = req_strobe;
    assign teletext_bit_o = q.ttx_bit;
    assign teletext_insert_o = q.ttx_insert;

endmodule // eot_output_control

// >>> tb/eot_output_control_sva.sv
`timescale 1ns/1ns
module eot_oc_sva
    import eot_pkg::*;
#(
    parameter logic REVISION_BIT = 1'b0
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input eot_pkg::eot_reg_req_t reg_req_i,
    input wire logic [7:0] reg_rdata_o,
    input eot_pkg::eot_ext_cfg_t ext_cfg_i,
    input wire logic [7:0] video_data_i,
    input wire logic vbi_active_i,
    input wire logic line_start_i,
    input wire logic [7:0] video_data_o,
    input wire logic video_blanked_o,
    input eot_pkg::eot_route_t dac_route_o,
    input wire logic [3:0] dac_enable_o,
    input wire logic teletext_request_strobe_o,
    input wire logic teletext_insert_o
);
    logic [7:0] m3_q;
    logic [7:0] tt_q;
    logic [11:0] since_q;
    // shadow of the two registers and cycles since the last line start
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            m3_q <= 8'h00;
            tt_q <= 8'h00;
        end else if (reg_req_i.wr && reg_req_i.addr == 8'h12) begin
            m3_q <= reg_req_i.wdata;
        end else if (reg_req_i.wr && reg_req_i.addr == 8'h24) begin
            tt_q <= reg_req_i.wdata;
        end
        since_q <= (!resetn_i || line_start_i) ? 12'h000 : since_q + 12'h001;
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_req_rise;
        $past(resetn_i) && $rose(teletext_request_strobe_o);
    endsequence
    sequence s_req_fall;
        $past(resetn_i) && $fell(teletext_request_strobe_o);
    endsequence
    a_readonly_bits: assert property (
        reg_req_i.rd && reg_req_i.addr == 8'h12 |=> reg_rdata_o[0] == REVISION_BIT
        && reg_rdata_o[5] == 1'b0 && reg_rdata_o[3:2] == 2'b00) else $error("mode bits wrong");
    a_vbi_blank: assert property (
        $past(resetn_i) && $past(vbi_active_i) |-> video_blanked_o == !($past(m3_q[1])
        && !$past(ext_cfg_i.slave_mode0) && !$past(ext_cfg_i.blank_input_control)))
        else $error("blanking wrong");
    a_ttx_gated: assert property (
        !m3_q[4] && !$past(m3_q[4]) |-> !teletext_request_strobe_o && !teletext_insert_o)
        else $error("teletext not gated");
    a_zero_colour: assert property (
        $past(video_data_i, 3) == 8'h00 && !$past(m3_q[6]) && !$past(vbi_active_i)
        |-> video_data_o == 8'h00) else $error("zero colour wrong");
    a_black_force: assert property (
        $past(video_data_i, 3) == 8'h00 && $past(m3_q[6]) |-> video_data_o == 8'h10)
        else $error("black not forced");
    a_route_dac_b: assert property (
        $past(resetn_i) |-> dac_route_o.dac_b == (!$past(ext_cfg_i.rgb_select) ? EOT_SIG_CVBS
        : $past(ext_cfg_i.yuv_select) ? EOT_SIG_U : EOT_SIG_B)) else $error("dac b route");
    a_dac_power: assert property (
        $past(resetn_i) |-> dac_enable_o == ~$past(ext_cfg_i.dac_power_down))
        else $error("dac enable wrong");
    a_rise_delay: assert property (
        s_req_rise |-> since_q == {8'h00, tt_q[7:4]}) else $error("rise late");
    a_fall_place: assert property (
        s_req_fall |-> since_q == {8'h00, tt_q[7:4]} + 12'h579 - {8'h00, tt_q[3:0]})
        else $error("fall wrong");
endmodule // eot_oc_sva

bind eot_output_control eot_oc_sva #(.REVISION_BIT(REVISION_BIT)) i_sva (
    .core_clk_i, .resetn_i, .reg_req_i, .reg_rdata_o, .ext_cfg_i, .video_data_i,
    .vbi_active_i, .line_start_i, .video_data_o, .video_blanked_o, .dac_route_o,
    .dac_enable_o, .teletext_request_strobe_o, .teletext_insert_o);

// >>> tb/eot_ttx_source.sv
`timescale 1ns/1ns
module eot_ttx_source (
    input wire logic core_clk_i,
    input wire logic request_i,
    output logic data_o
);
    logic [15:0] lfsr_q = 16'hace1;
    initial data_o = 1'b0;
    // fresh bits inside the window, toggling filler outside it
    always @(posedge core_clk_i) begin
        lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13]};
        data_o <= request_i ? lfsr_q[0] : ~data_o;
    end
endmodule // eot_ttx_source

// >>> tb/eot_output_control_tb.sv
`timescale 1ns/1ns
module eot_output_control_tb;
    import eot_pkg::*;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    eot_reg_req_t req = '0;
    eot_ext_cfg_t cfg = '0;
    logic [7:0] vin = 8'h00;
    logic vbi = 1'b0;
    logic ls = 1'b0;
    logic line_en = 1'b1;
    logic ttx_d;
    logic [7:0] rdata;
    logic [7:0] vout;
    eot_route_t route;
    logic [3:0] en;
    logic strobe;
    logic ins;
    logic tbit;
    int errors = 0;
    int tests_run = 0;
    always #50 core_clk_i = ~core_clk_i;
    eot_output_control i_dut (
        .core_clk_i, .resetn_i, .reg_req_i(req), .reg_rdata_o(rdata), .ext_cfg_i(cfg),
        .video_data_i(vin), .vbi_active_i(vbi), .line_start_i(ls),
        .ttx_line_enable_i(line_en), .teletext_data_input_i(ttx_d), .video_data_o(vout),
        .video_blanked_o(), .dac_route_o(route), .dac_enable_o(en),
        .teletext_request_strobe_o(strobe), .teletext_bit_o(tbit), .teletext_insert_o(ins));
    eot_ttx_source i_src (.core_clk_i, .request_i(strobe), .data_o(ttx_d));
    function automatic eot_route_t exp_route(input logic rgb, input logic yuv, input logic sw);
        eot_sig_t d;
        d = !rgb ? EOT_SIG_Y : (yuv ? EOT_SIG_Y : EOT_SIG_G);
        exp_route.dac_b = !rgb ? EOT_SIG_CVBS : (yuv ? EOT_SIG_U : EOT_SIG_B);
        exp_route.dac_c = !rgb ? EOT_SIG_C : (yuv ? EOT_SIG_V : EOT_SIG_R);
        exp_route.dac_a = sw ? d : EOT_SIG_CVBS;
        exp_route.dac_d = sw ? EOT_SIG_CVBS : d;
    endfunction
    function automatic logic [7:0] exp_vid(input logic [7:0] d, input logic [4:0] m);
        if (m[4] && !(m[0] && !m[2] && !m[3])) return 8'h10;
        return (m[1] && d == 8'h00) ? 8'h10 : d;
    endfunction
    task automatic summarize();
        $display("tests %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i) req <= '{1'b1, 1'b0, a, d};
        @(posedge core_clk_i) req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk_i) req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge core_clk_i) req <= '0;
        @(negedge core_clk_i) chk(rdata, e);
    endtask
    task automatic ttx(input logic [3:0] r, input logic [3:0] f, input int er);
        int n;
        wr(8'h24, {r, f});
        @(posedge core_clk_i) ls <= 1'b1;
        @(posedge core_clk_i) ls <= 1'b0;
        for (n = 0; strobe !== 1'b1 && n < 40; n++) @(negedge core_clk_i);
        chk(n, er);
        @(negedge core_clk_i) chk(ins, 32'(er < 40));
        for (n = 1; strobe === 1'b1 && n < 2000; n++) @(negedge core_clk_i);
        if (er < 40) chk(n, (360 * 144) / 37 - f);
        repeat (4) @(posedge core_clk_i);
        @(negedge core_clk_i) chk(tbit, 1'b0);
    endtask
    initial begin
        logic [7:0] d;
        void'($urandom(32'h7711400e));
        repeat (6) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        rd(8'h12, 8'h00);
        rd(8'h24, 8'h00);
        wr(8'h12, 8'hff);
        rd(8'h12, 8'hd2);
        d = 8'($urandom);
        wr(8'h24, d);
        rd(8'h24, d);
        rd(8'h13, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk_i) cfg.rgb_select <= i[2];
            @(posedge core_clk_i) cfg.yuv_select <= i[1];
            cfg.dac_power_down <= 4'($urandom);
            wr(8'h12, {i[0], 7'h00});
            repeat (2) @(posedge core_clk_i);
            @(negedge core_clk_i);
            chk(route, exp_route(i[2], i[1], i[0]));
            chk(en, 4'(~cfg.dac_power_down));
        end
        $display("test routing done");
        for (int i = 0; i < 32; i++) begin
            d = ($urandom % 2) ? 8'h00 : 8'($urandom);
            @(posedge core_clk_i) begin
                vin <= d;
                vbi <= i[4];
                cfg.slave_mode0 <= i[2];
                cfg.blank_input_control <= i[3];
            end
            wr(8'h12, {1'b0, i[1], 4'h0, i[0], 1'b0});
            repeat (4) @(posedge core_clk_i);
            @(negedge core_clk_i);
            chk(vout, exp_vid(d, 5'(i)));
        end
        $display("test video done");
        wr(8'h12, 8'h10);
        ttx(4'h0, 4'h0, 1);
        ttx(4'h3, 4'h0, 4);
        ttx(4'hf, 4'hf, 16);
        ttx(4'h0, 4'h5, 1);
        ttx(4'h9, 4'h5, 10);
        d = 8'($urandom);
        ttx(d[7:4], d[3:0], d[7:4] + 1);
        @(posedge core_clk_i) line_en <= 1'b0;
        ttx(4'h1, 4'h0, 40);
        @(posedge core_clk_i) line_en <= 1'b1;
        wr(8'h12, 8'h00);
        ttx(4'h2, 4'h0, 40);
        $display("test teletext done");
        summarize();
    end
    initial begin
        repeat (20000) @(posedge core_clk_i);
        errors++;
        summarize();
    end
endmodule // eot_output_control_tb
